// >>> hw/dmcr_regs.v
// Device misc control and status register bank with pin and clock control
`timescale 1ns/100ps
`include "dmcr_defines.vh"

module dmcr_regs #(
   parameter PAR_W  = 7,                   // Parity field width
   parameter ADDR_W = 12                   // RAM error address width
) (
   input  wire              clk_sys,       // System clock
   input  wire              sys_rst,       // Synchronous reset
   input  wire              regWrEn,       // Register write strobe
   input  wire              regRdEn,       // Register read strobe
   input  wire [2:0]        regIdx,        // Register index
   input  wire [31:0]       regWdata,      // Write data
   output reg  [31:0]       regRdata_q,    // Read data
   input  wire              cfgMode,       // Engine is in configuration mode
   input  wire              sleepReq,      // Engine requests sleep
   input  wire              oscStable,     // Oscillator running and stable
   input  wire              pllLock,       // PLL locked
   input  wire              sofPulse,      // Start-of-frame indication
   input  wire              transmitIrqFlag,
   input  wire              transmitIrqEnable,
   input  wire              receiveIrqFlag,
   input  wire              receiveIrqEnable,
   input  wire              canTxData,     // Engine transmit bit
   input  wire [1:0]        pinIn,         // Sensed pin levels
   input  wire              crcErrEvt,     // Checksum mismatch pulse
   input  wire              fmtErrEvt,     // Byte count mismatch pulse
   input  wire [15:0]       crcValue,      // Checksum of failing command
   input  wire              eccSecEvt,     // Single error corrected pulse
   input  wire              eccDedEvt,     // Double error detected pulse
   input  wire [ADDR_W-1:0] eccErrAddr,    // RAM address of error
   output reg               pllSelect_q,   // System clock from PLL
   output reg               sysClkDiv2_q,  // System clock halved
   output reg               sleepMode_q,   // Clock stopped, sleeping
   output reg               wakeCfg_q,     // Wake into configuration pulse
   output reg               clockOutPin_q, // Clock output pin
   output reg  [1:0]        pinOut_q,      // Pin output values
   output reg  [1:0]        pinOe_q,       // Pin output enables
   output reg               canTxOut_q,    // Transmit pin value
   output reg               canTxOe_q,     // Transmit pin enable
   output reg               stbyPin_q,     // Transceiver standby pin
   output reg               crcIrq_q,      // Checksum error request
   output reg               eccIrq_q,      // RAM error request
   output reg               eccEnable_q,   // RAM correction on
   output reg  [PAR_W-1:0]  eccParity_q    // Check bits for uncorrected writes
);

   // Oscillator control state
   reg [1:0]        clkOutDiv_q;           // Clock output divisor code
   reg              divSyncA_q;            // Divisor sync first stage
   reg              divSyncB_q;            // Divisor sync second stage
   reg [3:0]        coCnt_q;               // Clock output half period count
   reg              coToggle_q;            // Divided clock level
   reg [3:0]        coLimit;               // Half period for current code

   // Pin control state
   reg              irqOpenDrain_q;
   reg              txOpenDrain_q;
   reg              sofSel_q;
   reg              stbyEn_q;
   reg [1:0]        funcSel_q;             // One selects general purpose
   reg [1:0]        pinDir_q;              // One selects input
   reg [1:0]        pinLatch_q;            // Output latch

   // Checksum and RAM error state
   reg              crcErrFlag_q;
   reg              fmtErrFlag_q;
   reg              checksum_err_irq_en_q;
   reg              fmtErrIe_q;
   reg [15:0]       crcCapt_q;
   reg              single_err_irq_en_q;
   reg              double_err_irq_en_q;
   reg              secFlag_q;
   reg              dedFlag_q;
   reg [ADDR_W-1:0] ram_error_location_q;

   // Decoded writes
   wire wrOsc  = regWrEn && (regIdx == `DMCR_IDX_OSC);
   wire wrIo   = regWrEn && (regIdx == `DMCR_IDX_IOCTL);
   wire wrCrc  = regWrEn && (regIdx == `DMCR_IDX_CRC);
   wire wrEccC = regWrEn && (regIdx == `DMCR_IDX_ECCCTL);
   wire wrEccS = regWrEn && (regIdx == `DMCR_IDX_ECC_STATUS);
   wire [1:0] irqSrc = {receiveIrqFlag & receiveIrqEnable,
                        transmitIrqFlag & transmitIrqEnable};

   // Clock selection, locked outside configuration, and output divisor, writable in any mode
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         pllSelect_q  <= 1'b0;
         sysClkDiv2_q <= 1'b0;
         clkOutDiv_q  <= `DMCR_OSC_CODIV_RST;
      end else if (wrOsc) begin
         if (cfgMode) begin
            pllSelect_q  <= regWdata[`DMCR_OSC_PLLSEL];
            sysClkDiv2_q <= regWdata[`DMCR_OSC_SYSDIV];
         end
         clkOutDiv_q <= regWdata[`DMCR_OSC_COHI:`DMCR_OSC_COLO];
      end
   end

   // Oscillator disable: hardware sets, software clears by writing zero
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         sleepMode_q <= 1'b0;
         wakeCfg_q   <= 1'b0;
      end else begin
         // Set wins over a clear in the same cycle
         if (sleepReq) begin
            sleepMode_q <= 1'b1;
            wakeCfg_q   <= 1'b0;
         end else if (wrOsc && !regWdata[`DMCR_OSC_OSCILLATOR_DISABLE] && sleepMode_q) begin
            sleepMode_q <= 1'b0;
            wakeCfg_q   <= 1'b1;
         end else begin
            wakeCfg_q   <= 1'b0;
         end
      end
   end

   // Divisor setting carried into the clock domain
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         divSyncA_q <= 1'b0;
         divSyncB_q <= 1'b0;
      end else begin
         divSyncA_q <= sysClkDiv2_q;
         divSyncB_q <= divSyncA_q;
      end
   end

   // Half period selected by the output divisor code
   always @* begin
      case (clkOutDiv_q)
         2'h0:    coLimit = `DMCR_CODIV_1;
         2'h1:    coLimit = `DMCR_CODIV_2;
         2'h2:    coLimit = `DMCR_CODIV_4;
         2'h3:    coLimit = `DMCR_CODIV_10;
         default: coLimit = `DMCR_CODIV_1;
      endcase
   end

   // Clock output divider, held low while sleeping
   always @(posedge clk_sys) begin
      if (sys_rst || sleepMode_q) begin
         coCnt_q    <= 4'h0;
         coToggle_q <= 1'b0;
      end else if (coCnt_q + 4'h1 >= coLimit) begin
         coCnt_q    <= 4'h0;
         coToggle_q <= ~coToggle_q;
      end else begin
         coCnt_q    <= coCnt_q + 4'h1;
      end
   end

   // Clock output pin source select
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         clockOutPin_q <= 1'b0;
      end else if (sofSel_q) begin
         clockOutPin_q <= sofPulse;
      end else begin
         clockOutPin_q <= coToggle_q;
      end
   end

   // Pin control register
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         irqOpenDrain_q <= 1'b0;
         txOpenDrain_q  <= 1'b0;
         sofSel_q       <= 1'b0;
         stbyEn_q       <= 1'b0;
         funcSel_q      <= `DMCR_IO_FSEL_RST;
         pinDir_q       <= `DMCR_IO_DIR_RST;
         pinLatch_q     <= 2'h0;
      end else if (wrIo) begin
         irqOpenDrain_q <= regWdata[`DMCR_IO_IRQOD];
         txOpenDrain_q  <= regWdata[`DMCR_IO_TXOD];
         sofSel_q       <= regWdata[`DMCR_IO_SOF];
         stbyEn_q       <= regWdata[`DMCR_IO_STBYEN];
         funcSel_q      <= regWdata[`DMCR_IO_FSEL0+1:`DMCR_IO_FSEL0];
         pinDir_q       <= regWdata[`DMCR_IO_DIR0+1:`DMCR_IO_DIR0];
         pinLatch_q     <= regWdata[`DMCR_IO_PIN0_OUTPUT_LATCH+1:`DMCR_IO_PIN0_OUTPUT_LATCH];
      end
   end

   // Per pin drivers: interrupt output or general purpose pin
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : gPin
         reg lvl;       // Level the pin should show
         reg drive;     // Pin is an output
         always @* begin
            lvl   = 1'b1;
            drive = 1'b1;
            if (funcSel_q[gi]) begin
               lvl   = pinLatch_q[gi];
               drive = ~pinDir_q[gi];
            end else begin
               lvl   = ~irqSrc[gi];
               drive = 1'b1;
            end
         end
         always @(posedge clk_sys) begin
            if (sys_rst) begin
               pinOut_q[gi] <= 1'b0;
               pinOe_q[gi]  <= 1'b0;
            end else if (irqOpenDrain_q) begin
               pinOut_q[gi] <= 1'b0;
               pinOe_q[gi]  <= drive & ~lvl;
            end else begin
               pinOut_q[gi] <= lvl;
               pinOe_q[gi]  <= drive;
            end
         end
      end
   endgenerate

   // Transmit pin and standby pin
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         canTxOut_q <= 1'b0;
         canTxOe_q  <= 1'b0;
         stbyPin_q  <= 1'b0;
      end else begin
         if (txOpenDrain_q) begin
            canTxOut_q <= 1'b0;
            canTxOe_q  <= ~canTxData;
         end else begin
            canTxOut_q <= canTxData;
            canTxOe_q  <= 1'b1;
         end
         stbyPin_q <= stbyEn_q & sleepMode_q;
      end
   end

   // Checksum error flags, enables and captured value
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         crcErrFlag_q <= 1'b0;
         fmtErrFlag_q <= 1'b0;
         checksum_err_irq_en_q   <= 1'b0;
         fmtErrIe_q   <= 1'b0;
         crcCapt_q    <= 16'h0000;
      end else begin
         if (wrCrc) begin
            checksum_err_irq_en_q <= regWdata[`DMCR_CRC_ERRIE];
            fmtErrIe_q <= regWdata[`DMCR_CRC_FMTIE];
         end
         if (crcErrEvt) begin
            crcErrFlag_q <= 1'b1;
            crcCapt_q    <= crcValue;
         end else if (wrCrc && !regWdata[`DMCR_CRC_ERRF]) begin
            crcErrFlag_q <= 1'b0;
         end
         if (fmtErrEvt) begin
            fmtErrFlag_q <= 1'b1;
         end else if (wrCrc && !regWdata[`DMCR_CRC_FMTF]) begin
            fmtErrFlag_q <= 1'b0;
         end
      end
   end

   // RAM correction control
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         eccEnable_q <= 1'b0;
         single_err_irq_en_q     <= 1'b0;
         double_err_irq_en_q     <= 1'b0;
         eccParity_q <= {PAR_W{1'b0}};
      end else if (wrEccC) begin
         eccEnable_q <= regWdata[`DMCR_ECC_EN];
         single_err_irq_en_q     <= regWdata[`DMCR_ECC_SINGLE_ERR_IRQ_EN];
         double_err_irq_en_q     <= regWdata[`DMCR_ECC_DOUBLE_ERR_IRQ_EN];
         eccParity_q <= regWdata[`DMCR_ECC_PLO+PAR_W-1:`DMCR_ECC_PLO];
      end
   end

   // RAM error flags and address of last error
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         secFlag_q <= 1'b0;
         dedFlag_q <= 1'b0;
         ram_error_location_q <= {ADDR_W{1'b0}};
      end else begin
         if (eccSecEvt || eccDedEvt) begin
            ram_error_location_q <= eccErrAddr;
         end
         if (eccSecEvt) begin
            secFlag_q <= 1'b1;
         end else if (wrEccS && !regWdata[`DMCR_ECC_SECF]) begin
            secFlag_q <= 1'b0;
         end
         if (eccDedEvt) begin
            dedFlag_q <= 1'b1;
         end else if (wrEccS && !regWdata[`DMCR_ECC_DEDF]) begin
            dedFlag_q <= 1'b0;
         end
      end
   end

   // Gated interrupt requests
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         crcIrq_q <= 1'b0;
         eccIrq_q <= 1'b0;
      end else begin
         crcIrq_q <= (crcErrFlag_q & checksum_err_irq_en_q) | (fmtErrFlag_q & fmtErrIe_q);
         eccIrq_q <= (secFlag_q & single_err_irq_en_q) | (dedFlag_q & double_err_irq_en_q);
      end
   end

   // Read data assembly; unmapped indices and unused bits read zero
   reg [31:0] rdMux;
   always @* begin
      rdMux = 32'h00000000;
      case (regIdx)
         `DMCR_IDX_OSC: begin
            rdMux[`DMCR_OSC_PLLSEL]  = pllSelect_q;
            rdMux[`DMCR_OSC_OSCILLATOR_DISABLE]  = sleepMode_q;
            rdMux[`DMCR_OSC_SYSDIV]  = sysClkDiv2_q;
            rdMux[`DMCR_OSC_COHI:`DMCR_OSC_COLO] = clkOutDiv_q;
            rdMux[`DMCR_OSC_PLL_LOCKED_FLAG]  = pllLock;
            rdMux[`DMCR_OSC_CLKRDY]  = oscStable & ~sleepMode_q;
            rdMux[`DMCR_OSC_DIVSYNC] = divSyncB_q;
         end
         `DMCR_IDX_IOCTL: begin
            rdMux[`DMCR_IO_DIR0+1:`DMCR_IO_DIR0]   = pinDir_q;
            rdMux[`DMCR_IO_STBYEN]                 = stbyEn_q;
            rdMux[`DMCR_IO_PIN0_OUTPUT_LATCH+1:`DMCR_IO_PIN0_OUTPUT_LATCH]   = pinLatch_q;
            rdMux[`DMCR_IO_LVL0+1:`DMCR_IO_LVL0]   = pinIn;
            rdMux[`DMCR_IO_FSEL0+1:`DMCR_IO_FSEL0] = funcSel_q;
            rdMux[`DMCR_IO_TXOD]                   = txOpenDrain_q;
            rdMux[`DMCR_IO_SOF]                    = sofSel_q;
            rdMux[`DMCR_IO_IRQOD]                  = irqOpenDrain_q;
         end
         `DMCR_IDX_CRC: begin
            rdMux[`DMCR_CRC_VHI:`DMCR_CRC_VLO] = crcCapt_q;
            rdMux[`DMCR_CRC_ERRF]  = crcErrFlag_q;
            rdMux[`DMCR_CRC_FMTF]  = fmtErrFlag_q;
            rdMux[`DMCR_CRC_ERRIE] = checksum_err_irq_en_q;
            rdMux[`DMCR_CRC_FMTIE] = fmtErrIe_q;
         end
         `DMCR_IDX_ECCCTL: begin
            rdMux[`DMCR_ECC_EN]    = eccEnable_q;
            rdMux[`DMCR_ECC_SINGLE_ERR_IRQ_EN] = single_err_irq_en_q;
            rdMux[`DMCR_ECC_DOUBLE_ERR_IRQ_EN] = double_err_irq_en_q;
            rdMux[`DMCR_ECC_PLO+PAR_W-1:`DMCR_ECC_PLO] = eccParity_q;
         end
         `DMCR_IDX_ECC_STATUS: begin
            rdMux[`DMCR_ECC_SECF] = secFlag_q;
            rdMux[`DMCR_ECC_DEDF] = dedFlag_q;
            rdMux[`DMCR_ECC_ALO+ADDR_W-1:`DMCR_ECC_ALO] = ram_error_location_q;
         end
         default: rdMux = 32'h00000000;
      endcase
   end

   // Registered read data, updated on a read strobe
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         regRdata_q <= 32'h00000000;
      end else if (regRdEn) begin
         regRdata_q <= rdMux;
      end
   end

endmodule // dmcr_regs

// >>> shared/dmcr_defines.vh
// Constants for the device misc control register bank
`ifndef DMCR_DEFINES_VH
`define DMCR_DEFINES_VH
// Register indices on the register port
`define DMCR_IDX_OSC      3'h0
`define DMCR_IDX_IOCTL    3'h1
`define DMCR_IDX_CRC      3'h2
`define DMCR_IDX_ECCCTL   3'h3
`define DMCR_IDX_ECC_STATUS  3'h4
// Oscillator control fields
`define DMCR_OSC_PLLSEL   0
`define DMCR_OSC_OSCILLATOR_DISABLE   2
`define DMCR_OSC_SYSDIV   4
`define DMCR_OSC_COLO     5
`define DMCR_OSC_COHI     6
`define DMCR_OSC_PLL_LOCKED_FLAG   8
`define DMCR_OSC_CLKRDY   10
`define DMCR_OSC_DIVSYNC  12
`define DMCR_OSC_CODIV_RST 2'h3
// Pin control fields
`define DMCR_IO_DIR0      0
`define DMCR_IO_STBYEN    6
`define DMCR_IO_PIN0_OUTPUT_LATCH      8
`define DMCR_IO_LVL0      16
`define DMCR_IO_FSEL0     24
`define DMCR_IO_TXOD      28
`define DMCR_IO_SOF       29
`define DMCR_IO_IRQOD     30
`define DMCR_IO_DIR_RST   2'h3
`define DMCR_IO_FSEL_RST  2'h3
// Checksum register fields
`define DMCR_CRC_VLO      0
`define DMCR_CRC_VHI      15
`define DMCR_CRC_ERRF     16
`define DMCR_CRC_FMTF     17
`define DMCR_CRC_ERRIE    24
`define DMCR_CRC_FMTIE    25
// RAM correction fields
`define DMCR_ECC_EN       0
`define DMCR_ECC_SINGLE_ERR_IRQ_EN    1
`define DMCR_ECC_DOUBLE_ERR_IRQ_EN    2
`define DMCR_ECC_PLO      8
`define DMCR_ECC_PHI      14
`define DMCR_ECC_SECF     1
`define DMCR_ECC_DEDF     2
`define DMCR_ECC_ALO      16
`define DMCR_ECC_AHI      27
// Clock output divide counts, in half periods
`define DMCR_CODIV_1      4'h1
`define DMCR_CODIV_2      4'h2
`define DMCR_CODIV_4      4'h4
`define DMCR_CODIV_10     4'ha
`endif

// >>> test/dmcr_regs_monitor.sv
// Port timing checks for the misc control register bank
`timescale 1ns/100ps
module dmcr_regs_monitor (
   input wire        clk_sys,
   input wire        sys_rst,
   input wire        regWrEn,
   input wire        regRdEn,
   input wire [2:0]  regIdx,
   input wire [31:0] regWdata,
   input wire [31:0] regRdata_q,
   input wire        cfgMode,
   input wire        sleepReq,
   input wire        pllSelect_q,
   input wire        sysClkDiv2_q,
   input wire        sleepMode_q,
   input wire        wakeCfg_q,
   input wire        clockOutPin_q,
   input wire        stbyPin_q
);
   // One clock domain, reset masks all checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // Write to oscillator control
   wire oscWr = regWrEn && regIdx == 3'h0;
   // Software wake request while asleep
   sequence s_wakeReq;
      sleepMode_q && !sleepReq && oscWr && !regWdata[2];
   endsequence
   // Awake with a one-cycle wake pulse
   sequence s_wakeDone;
      !sleepMode_q && wakeCfg_q ##1 !wakeCfg_q;
   endsequence
   // Asleep for three edges
   sequence s_asleep;
      sleepMode_q [*3];
   endsequence
   a_cfg_gate: assert property (
      oscWr && !cfgMode |=> $stable(pllSelect_q) && $stable(sysClkDiv2_q))
      else $error("clock select changed outside configuration");
   a_cfg_write: assert property (
      oscWr && cfgMode |=> pllSelect_q == $past(regWdata[0]) && sysClkDiv2_q == $past(regWdata[4]))
      else $error("clock select write not applied");
   a_sleep_set: assert property (
      sleepReq |=> sleepMode_q)
      else $error("sleep request did not stop clock");
   a_wake_seq: assert property (
      s_wakeReq |=> s_wakeDone)
      else $error("wake sequence wrong");
   a_wake_cause: assert property (
      $rose(wakeCfg_q) |-> $past(sleepMode_q) && !sleepMode_q)
      else $error("wake pulse without leaving sleep");
   a_clk_hold: assert property (
      s_asleep |-> !clockOutPin_q)
      else $error("clock output toggling while asleep");
   a_stby_awake: assert property (
      !sleepMode_q && !$past(sleepMode_q) |-> !stbyPin_q)
      else $error("standby pin high while awake");
   a_osc_unused: assert property (
      regRdEn && regIdx == 3'h0 |=> (regRdata_q & 32'hffffea8a) == 32'h0)
      else $error("unimplemented oscillator bits read nonzero");
   a_idx_unmapped: assert property (
      regRdEn && regIdx > 3'h4 |=> regRdata_q == 32'h0)
      else $error("unmapped index read nonzero");
endmodule // dmcr_regs_monitor

bind dmcr_regs dmcr_regs_monitor mon (
   .clk_sys, .sys_rst, .regWrEn, .regRdEn, .regIdx, .regWdata, .regRdata_q, .cfgMode,
   .sleepReq, .pllSelect_q, .sysClkDiv2_q, .sleepMode_q, .wakeCfg_q, .clockOutPin_q, .stbyPin_q
);

// >>> test/dmcr_host.sv
// Host controller model issuing register port accesses
`timescale 1ns/100ps
module dmcr_host (
   input  wire        clk_sys,
   input  wire [31:0] regRdata_q,
   output reg         regWrEn,
   output reg         regRdEn,
   output reg  [2:0]  regIdx,
   output reg  [31:0] regWdata
);
   // Idle bus at time zero
   initial begin
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regIdx = 3'h0;
      regWdata = 32'h0;
   end
   // Word write, taken at the second edge
   task wr(input [2:0] idx, input [31:0] data);
      begin
         @(posedge clk_sys);
         regWrEn <= 1'b1;
         regIdx <= idx;
         regWdata <= data;
         @(posedge clk_sys);
         regWrEn <= 1'b0;
         regWdata <= ~data; // No stale data left on the bus
      end
   endtask
   // Word read, data sampled 1 ns after the taking edge
   task rd(input [2:0] idx, output [31:0] data);
      begin
         @(posedge clk_sys);
         regRdEn <= 1'b1;
         regIdx <= idx;
         @(posedge clk_sys);
         regRdEn <= 1'b0;
         #1 data = regRdata_q;
      end
   endtask
endmodule // dmcr_host

// >>> test/dmcr_regs_test.sv
// Directed testbench for the misc control register bank
`timescale 1ns/100ps
`include "dmcr_defines.vh"
module dmcr_regs_test;
   reg clk_sys = 0, sys_rst = 1, cfgMode = 0, sleepReq = 0, oscStable = 0, pllLock = 0, sofPulse = 0;
   reg transmitIrqFlag = 1, transmitIrqEnable = 1, receiveIrqFlag = 0, receiveIrqEnable = 1;
   reg canTxData = 1, crcErrEvt = 0, fmtErrEvt = 0, eccSecEvt = 0, eccDedEvt = 0;
   reg  [1:0]  pinIn = 2'h0;
   reg  [15:0] crcValue = 16'hbeef;
   reg  [11:0] eccErrAddr = 12'habc;
   wire regWrEn, regRdEn, pllSelect_q, sysClkDiv2_q, sleepMode_q, wakeCfg_q, clockOutPin_q;
   wire canTxOut_q, canTxOe_q, stbyPin_q, crcIrq_q, eccIrq_q, eccEnable_q;
   wire [2:0]  regIdx;
   wire [31:0] regWdata, regRdata_q;
   wire [1:0]  pinOut_q, pinOe_q;
   wire [6:0]  eccParity_q;
   integer     error_cnt = 0, num_checks = 0, cyc = 0, i, n;
   reg  [31:0] d;
   // 25 MHz clock
   always #20 clk_sys = ~clk_sys;
   dmcr_host host (.clk_sys, .regRdata_q, .regWrEn, .regRdEn, .regIdx, .regWdata);
   dmcr_regs DUT (.clk_sys, .sys_rst, .regWrEn, .regRdEn, .regIdx, .regWdata, .regRdata_q,
      .cfgMode, .sleepReq, .oscStable, .pllLock, .sofPulse, .transmitIrqFlag, .transmitIrqEnable,
      .receiveIrqFlag, .receiveIrqEnable, .canTxData, .pinIn, .crcErrEvt, .fmtErrEvt, .crcValue,
      .eccSecEvt, .eccDedEvt, .eccErrAddr, .pllSelect_q, .sysClkDiv2_q, .sleepMode_q, .wakeCfg_q,
      .clockOutPin_q, .pinOut_q, .pinOe_q, .canTxOut_q, .canTxOe_q, .stbyPin_q, .crcIrq_q,
      .eccIrq_q, .eccEnable_q, .eccParity_q);
   // Verdict and end of run
   task report_and_stop;
      begin
         if (error_cnt == 0 && num_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // Compare seen against expected
   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Read a register and compare
   task rchk(input [2:0] idx, input [31:0] exp);
      begin
         host.rd(idx, d);
         chk(d, exp);
      end
   endtask
   task tick(input integer k);
      repeat (k) @(posedge clk_sys);
   endtask
   // One-cycle event pulse, then settle
   task ev(input integer k);
      begin
         @(posedge clk_sys);
         case (k)
            0: crcErrEvt <= 1'b1;
            1: fmtErrEvt <= 1'b1;
            2: eccSecEvt <= 1'b1;
            default: eccDedEvt <= 1'b1;
         endcase
         @(posedge clk_sys);
         {crcErrEvt, fmtErrEvt, eccSecEvt, eccDedEvt} <= 4'h0;
         tick(2);
      end
   endtask
   // Clock output period in cycles, bounded waits
   task per(output integer p);
      begin
         p = 0;
         for (i = 0; i < 40 && clockOutPin_q; i = i + 1) @(posedge clk_sys);
         for (i = 0; i < 40 && !clockOutPin_q; i = i + 1) @(posedge clk_sys);
         for (i = 0; i < 40 && clockOutPin_q; i = i + 1) begin
            @(posedge clk_sys);
            p = p + 1;
         end
         for (i = 0; i < 40 && !clockOutPin_q; i = i + 1) begin
            @(posedge clk_sys);
            p = p + 1;
         end
      end
   endtask
   // Hang guard
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 4000) begin
         error_cnt = error_cnt + 1;
         report_and_stop;
      end
   end
   // Main sequence
   initial begin
      tick(5);
      sys_rst <= 1'b0;
      rchk(`DMCR_IDX_OSC, 32'h60);
      rchk(`DMCR_IDX_IOCTL, 32'h03000003);
      for (n = 2; n < 8; n = n + 1) begin
         if (n > 4) host.wr(n[2:0], 32'hffffffff);
         rchk(n[2:0], 32'h0);
      end
      host.wr(`DMCR_IDX_OSC, 32'h71);
      rchk(`DMCR_IDX_OSC, 32'h60);
      @(posedge clk_sys);
      cfgMode <= 1'b1;
      oscStable <= 1'b1;
      pllLock <= 1'b1;
      host.wr(`DMCR_IDX_OSC, 32'h71);
      tick(3);
      chk({pllSelect_q, sysClkDiv2_q}, 2'h3);
      rchk(`DMCR_IDX_OSC, 32'h1571);
      @(posedge clk_sys);
      cfgMode <= 1'b0;
      for (n = 0; n < 4; n = n + 1) begin
         host.wr(`DMCR_IDX_OSC, n << 5);
         tick(4);
         per(d);
         chk(d, n == 3 ? 20 : 2 << n);
      end
      host.wr(`DMCR_IDX_IOCTL, 32'h20000003);
      @(posedge clk_sys);
      sofPulse <= 1'b1;
      tick(3);
      chk(clockOutPin_q, 1'b1);
      sofPulse <= 1'b0;
      tick(3);
      chk(clockOutPin_q, 1'b0);
      host.wr(`DMCR_IDX_IOCTL, 32'h3);
      tick(3);
      chk({pinOe_q, pinOut_q}, 4'he);
      host.wr(`DMCR_IDX_IOCTL, 32'h40000003);
      tick(3);
      chk({pinOe_q, pinOut_q}, 4'h4);
      receiveIrqFlag <= 1'b1;
      tick(3);
      chk({pinOe_q, pinOut_q}, 4'hc);
      receiveIrqFlag <= 1'b0;
      pinIn <= 2'h2;
      host.wr(`DMCR_IDX_IOCTL, 32'h03000102);
      tick(3);
      chk({pinOe_q, pinOut_q[0], canTxOut_q, canTxOe_q}, 5'h0f);
      rchk(`DMCR_IDX_IOCTL, 32'h03020102);
      host.wr(`DMCR_IDX_IOCTL, 32'h13000102);
      tick(3);
      chk({canTxOut_q, canTxOe_q}, 2'h0);
      canTxData <= 1'b0;
      tick(3);
      chk({canTxOut_q, canTxOe_q}, 2'h1);
      host.wr(`DMCR_IDX_IOCTL, 32'h43);
      tick(3);
      chk(stbyPin_q, 1'b0);
      sleepReq <= 1'b1;
      @(posedge clk_sys);
      sleepReq <= 1'b0;
      tick(3);
      chk({sleepMode_q, stbyPin_q, clockOutPin_q}, 3'h6);
      rchk(`DMCR_IDX_OSC, 32'h1175);
      host.wr(`DMCR_IDX_OSC, 32'h60);
      #1 chk({sleepMode_q, wakeCfg_q}, 2'h1);
      rchk(`DMCR_IDX_OSC, 32'h1571);
      host.wr(`DMCR_IDX_CRC, 32'h03000000);
      ev(0);
      rchk(`DMCR_IDX_CRC, 32'h0301beef);
      chk(crcIrq_q, 1'b1);
      ev(1);
      rchk(`DMCR_IDX_CRC, 32'h0303beef);
      fork
         host.wr(`DMCR_IDX_CRC, 32'h03000000);
         ev(0);
      join
      rchk(`DMCR_IDX_CRC, 32'h0301beef);
      host.wr(`DMCR_IDX_CRC, 32'h01000000);
      rchk(`DMCR_IDX_CRC, 32'h0100beef);
      chk(crcIrq_q, 1'b0);
      host.wr(`DMCR_IDX_CRC, 32'h0);
      ev(0);
      chk(crcIrq_q, 1'b0);
      host.wr(`DMCR_IDX_ECCCTL, 32'h7f07);
      tick(1);
      chk({eccEnable_q, eccParity_q}, 8'hff);
      rchk(`DMCR_IDX_ECCCTL, 32'h7f07);
      ev(2);
      rchk(`DMCR_IDX_ECC_STATUS, 32'h0abc0002);
      chk(eccIrq_q, 1'b1);
      @(posedge clk_sys);
      eccErrAddr <= 12'h123;
      ev(3);
      rchk(`DMCR_IDX_ECC_STATUS, 32'h01230006);
      host.wr(`DMCR_IDX_ECC_STATUS, 32'h6);
      rchk(`DMCR_IDX_ECC_STATUS, 32'h01230006);
      host.wr(`DMCR_IDX_ECC_STATUS, 32'h0);
      tick(2);
      chk(eccIrq_q, 1'b0);
      rchk(`DMCR_IDX_ECC_STATUS, 32'h01230000);
      host.wr(`DMCR_IDX_ECCCTL, 32'h0500);
      tick(1);
      chk({eccEnable_q, eccParity_q}, 8'h05);
      report_and_stop;
   end
endmodule // dmcr_regs_test
